// file: hdl/nip_pkg.sv
// Constants and types for the node identity and PHY register access block.
// Assumes an APB master with a 12-bit byte address and a link-PHY pin pair.
// Behaviour
// - Node ID is bus number in bits 15..6 joined with node number in 5..0.
// - Valid flag bit 31 clears on bus reset, sets when a node number arrives.
// - Root flag bit 30 is set when the PHY reports being root.
// - Cable power flag bit 27 follows the PHY's cable power report.
// - Bus number field is software read/write and resets to all ones.
// - Node number loads from the PHY after self-ID; software cannot write it.
// - Node identity bits 29..28 and 26..16 read as zero.
// - Done flag clears when software sets the read or write request bit.
// - Done flag sets when a register transfer arrives from the PHY.
// - Bits 27..24 capture the address of the latest PHY register transfer.
// - Bits 23..16 capture the register data returned by the PHY.
// - Bit 15 requests a PHY read; hardware clears it once sent.
// - Bit 14 requests a PHY write; hardware clears it once sent.
// - Software sets target address bits 11..8 before requesting.
// - Bits 7..0 are sent as write data; ignored for reads.
// - PHY access bits 30..28 and 13..12 read as zero.

package nip_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam logic [11:0] OFS_NODE_ID = 12'h0e8;
  localparam logic [11:0] OFS_PHY_ACC = 12'h0ec;

  // Node identity layout
  localparam int unsigned NID_VALID  = 31;
  localparam int unsigned NID_ROOT   = 30;
  localparam int unsigned NID_CPS    = 27;
  localparam int unsigned NID_BUS_LO = 6;
  localparam int unsigned BUS_W      = 10;
  localparam int unsigned NODE_W     = 6;
  localparam logic [9:0]  BUS_RESET  = 10'h3ff;
  localparam logic [5:0]  NODE_RESET = 6'h00;

  // PHY access layout
  localparam int unsigned PA_DONE  = 31;
  localparam int unsigned PA_RA_LO = 24;
  localparam int unsigned PA_RD_LO = 16;
  localparam int unsigned PA_RDREQ = 15;
  localparam int unsigned PA_WRREQ = 14;
  localparam int unsigned PA_TA_LO = 8;
  localparam int unsigned PA_WV_LO = 0;

  // Status transfer: two bits a symbol, eight symbols, first bit on lane 1
  // Each symbol stands two cycles so that it survives the pin filter
  localparam logic [1:0] CTL_STATUS = 2'h1;
  localparam logic [2:0] ST_LAST    = 3'h7;
  localparam logic [2:0] BR_CYC     = 3'h1;
  localparam int unsigned BR_LANE   = 1;
  localparam int unsigned ST_ADDR_LO = 8;
  localparam logic [3:0] PHY_REG_ID = 4'h0;
  localparam int unsigned ID_LO     = 2;
  localparam int unsigned ID_ROOT   = 1;
  localparam int unsigned ID_CPS    = 0;

  // Request line framing
  localparam logic [2:0] LRQ_RD  = 3'h4;
  localparam logic [2:0] LRQ_WR  = 3'h5;
  localparam logic [4:0] LEN_RD  = 5'h09;
  localparam logic [4:0] LEN_WR  = 5'h11;

  typedef struct packed {
    logic       isWrite;
    logic [3:0] addr;
    logic [7:0] data;
  } nip_preq_t;
endpackage : nip_pkg

// file: hdl/nip_sync.sv
// Pin synchroniser: three flops and an output flop; output moves once stages two and three agree.
// Assumes inputs are asynchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module nip_sync #(
  parameter int unsigned W = 4
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Pins in, filtered levels out
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } nip_sync_t;

  nip_sync_t st_ff;
  nip_sync_t nxt_st;

  always_comb begin
    nxt_st    = st_ff;
    nxt_st.s1 = din;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    // Stage one feeds stage two only; agreement filters a single glitch
    if (st_ff.s2 == st_ff.s3) begin
      nxt_st.q = st_ff.s3;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign dout = st_ff.q;
endmodule : nip_sync
`default_nettype wire

// file: hdl/nip_lreq.sv
// Serial request sender for the link request pin.
// Assumes the caller holds start for one cycle only while idle.
`timescale 1ns/1ps
`default_nettype none
module nip_lreq (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Request from the register side
  input  wire logic              start,
  input  wire nip_pkg::nip_preq_t req,
  output logic                   busy,
  output logic                   done,
  // Pin
  output logic                   lreq
);
  typedef struct packed {
    logic        busy;
    logic [4:0]  cnt;
    logic [16:0] sh;
  } nip_lsr_t;

  nip_lsr_t st_ff;
  nip_lsr_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (start) begin
      nxt_st.busy = 1'b1;
      if (req.isWrite) begin
        nxt_st.cnt = nip_pkg::LEN_WR;
        nxt_st.sh  = {1'b1, nip_pkg::LRQ_WR, req.addr, req.data, 1'b0};
      end else begin
        // Data byte is dropped for reads
        nxt_st.cnt = nip_pkg::LEN_RD;
        nxt_st.sh  = {1'b1, nip_pkg::LRQ_RD, req.addr, 9'h000};
      end
    end else if (st_ff.busy) begin
      nxt_st.sh  = {st_ff.sh[15:0], 1'b0};
      nxt_st.cnt = st_ff.cnt - 5'h01;
      if (st_ff.cnt == 5'h01) begin
        nxt_st.busy = 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign busy = st_ff.busy;
  assign done = st_ff.busy && (st_ff.cnt == 5'h01);
  assign lreq = st_ff.busy && st_ff.sh[16];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_hdr;
    lreq ##1 lreq ##1 !lreq ##1 (lreq == $past(req.isWrite, 4));
  endsequence

  property p_frame_hdr;
    start |=> s_hdr;
  endproperty
  a_frame_hdr: assert property (p_frame_hdr) else $error("request header wrong");

  property p_wr_data;
    start && req.isWrite |=> ##8 (lreq == $past(req.data[7], 9));
  endproperty
  a_wr_data: assert property (p_wr_data) else $error("write data msb not sent");

  property p_rd_len;
    start && !req.isWrite |=> busy [*8] ##1 busy ##1 !busy;
  endproperty
  a_rd_len: assert property (p_rd_len) else $error("read frame length wrong");
endmodule : nip_lreq
`default_nettype wire

// file: hdl/nip_top.sv
// Node identity and PHY register access registers behind an APB slave.
// Assumes PHY pins asynchronous to clk; APB master on clk; zero wait states.
`timescale 1ns/1ps
`default_nettype none
module nip_top (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Link-PHY pins
  input  wire logic [1:0]  phyCtl,
  input  wire logic [1:0]  phyData,
  output logic             phyLreq,
  // Node status to the link
  output logic             identifierValid,
  output logic [15:0]      nodeId
);
  typedef struct packed {
    logic [9:0]  busNumberField;
    logic [5:0]  physicalNodeNumber;
    logic        identifierValid;
    logic        root;
    logic        cablePowerOk;
    logic        phyAccessDone;
    logic [3:0]  returnedPhyAddress;
    logic [7:0]  returnedPhyData;
    logic        phyReadRequest;
    logic        phyWriteRequest;
    logic [3:0]  targetPhyAddress;
    logic [7:0]  phyWriteValue;
    logic        sent;
    logic        sentWr;
    logic [15:0] stWord;
    logic [2:0]  stCnt;
    logic        stPh;
    logic [31:0] prdata;
  } nip_state_t;

  nip_state_t        st_ff;
  nip_state_t        nxt_st;
  logic [3:0]        pinS;
  logic [1:0]        ctlS;
  logic [1:0]        datS;
  logic              isStat;
  logic              regXfer;
  logic              busRstEv;
  logic [15:0]       rxWord;
  logic [3:0]        rxAddr;
  logic [7:0]        rxData;
  logic              apbWr;
  logic              apbSetup;
  logic              selNode;
  logic              selPhy;
  logic              swReq;
  logic              start;
  logic              lrqDone;
  nip_pkg::nip_preq_t preq;
  logic [31:0]       nodeWord;
  logic [31:0]       phyWord;

  nip_sync #(
    .W (4)
  ) uSync (
    .clk   (clk),
    .rst_n (rst_n),
    .din   ({phyCtl, phyData}),
    .dout  (pinS)
  );

  nip_lreq uLreq (
    .clk   (clk),
    .rst_n (rst_n),
    .start (start),
    .req   (preq),
    .busy  (),
    .done  (lrqDone),
    .lreq  (phyLreq)
  );

  // PHY status reception
  assign ctlS     = pinS[3:2];
  assign datS     = pinS[1:0];
  assign isStat   = (ctlS == nip_pkg::CTL_STATUS);
  assign rxWord   = {st_ff.stWord[13:0], datS};
  // Act on the first cycle of each two-cycle symbol only
  assign regXfer  = isStat && !st_ff.stPh && (st_ff.stCnt == nip_pkg::ST_LAST);
  assign busRstEv = isStat && !st_ff.stPh && (st_ff.stCnt == nip_pkg::BR_CYC) && datS[nip_pkg::BR_LANE];
  assign rxAddr   = rxWord[nip_pkg::ST_ADDR_LO +: 4];
  assign rxData   = rxWord[7:0];

  // APB decode
  assign apbWr    = psel && penable && pwrite;
  assign apbSetup = psel && !penable;
  assign selNode  = (paddr == nip_pkg::OFS_NODE_ID);
  assign selPhy   = (paddr == nip_pkg::OFS_PHY_ACC);
  assign swReq    = apbWr && selPhy && (pwdata[nip_pkg::PA_RDREQ] || pwdata[nip_pkg::PA_WRREQ]);

  // Read wins if software breaks the one-request-at-a-time convention
  assign start        = (st_ff.phyReadRequest || st_ff.phyWriteRequest) && !st_ff.sent;
  assign preq.isWrite = !st_ff.phyReadRequest;
  assign preq.addr    = st_ff.targetPhyAddress;
  assign preq.data    = st_ff.phyWriteValue;

  always_comb begin
    nodeWord = '0;
    nodeWord[nip_pkg::NID_VALID] = st_ff.identifierValid;
    nodeWord[nip_pkg::NID_ROOT]  = st_ff.root;
    nodeWord[nip_pkg::NID_CPS]   = st_ff.cablePowerOk;
    nodeWord[15:0] = {st_ff.busNumberField, st_ff.physicalNodeNumber};
  end

  always_comb begin
    phyWord = '0;
    phyWord[nip_pkg::PA_DONE]         = st_ff.phyAccessDone;
    phyWord[nip_pkg::PA_RA_LO +: 4]   = st_ff.returnedPhyAddress;
    phyWord[nip_pkg::PA_RD_LO +: 8]   = st_ff.returnedPhyData;
    phyWord[nip_pkg::PA_RDREQ]        = st_ff.phyReadRequest;
    phyWord[nip_pkg::PA_WRREQ]        = st_ff.phyWriteRequest;
    phyWord[nip_pkg::PA_TA_LO +: 4]   = st_ff.targetPhyAddress;
    phyWord[nip_pkg::PA_WV_LO +: 8]   = st_ff.phyWriteValue;
  end

  always_comb begin
    nxt_st = st_ff;
    // Status shifter: one shift per symbol; a burst restarts when control leaves status
    nxt_st.stPh = isStat && !st_ff.stPh;
    if (isStat && !st_ff.stPh) begin
      nxt_st.stWord = rxWord;
      nxt_st.stCnt  = st_ff.stCnt + 3'h1;
    end
    if (!isStat) begin
      nxt_st.stCnt = '0;
    end
    if (busRstEv) begin
      nxt_st.identifierValid = 1'b0;
    end
    // Request line handshake: hardware clear first, a same-cycle software set overrides
    if (start) begin
      nxt_st.sent   = 1'b1;
      nxt_st.sentWr = preq.isWrite;
    end
    if (lrqDone) begin
      nxt_st.sent = 1'b0;
      if (st_ff.sentWr) begin
        nxt_st.phyWriteRequest = 1'b0;
      end else begin
        nxt_st.phyReadRequest = 1'b0;
      end
    end
    // Software writes
    if (apbWr && selNode) begin
      nxt_st.busNumberField = pwdata[nip_pkg::NID_BUS_LO +: nip_pkg::BUS_W];
    end
    if (apbWr && selPhy) begin
      nxt_st.targetPhyAddress = pwdata[nip_pkg::PA_TA_LO +: 4];
      nxt_st.phyWriteValue    = pwdata[nip_pkg::PA_WV_LO +: 8];
      if (pwdata[nip_pkg::PA_RDREQ]) begin
        nxt_st.phyReadRequest = 1'b1;
      end
      if (pwdata[nip_pkg::PA_WRREQ]) begin
        nxt_st.phyWriteRequest = 1'b1;
      end
    end
    if (swReq) begin
      nxt_st.phyAccessDone = 1'b0;
    end
    // Returned register transfer; set wins over the software clear
    if (regXfer) begin
      nxt_st.phyAccessDone      = 1'b1;
      nxt_st.returnedPhyAddress = rxAddr;
      nxt_st.returnedPhyData    = rxData;
      if (rxAddr == nip_pkg::PHY_REG_ID) begin
        nxt_st.physicalNodeNumber = rxData[nip_pkg::ID_LO +: nip_pkg::NODE_W];
        nxt_st.root               = rxData[nip_pkg::ID_ROOT];
        nxt_st.cablePowerOk       = rxData[nip_pkg::ID_CPS];
        nxt_st.identifierValid    = 1'b1;
      end
    end
    // Read data captured in the setup phase, presented in the access phase
    if (apbSetup) begin
      if (selNode) begin
        nxt_st.prdata = nodeWord;
      end else if (selPhy) begin
        nxt_st.prdata = phyWord;
      end else begin
        nxt_st.prdata = '0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_ff                    <= '0;
      st_ff.busNumberField     <= nip_pkg::BUS_RESET;
      st_ff.physicalNodeNumber <= nip_pkg::NODE_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign prdata          = st_ff.prdata;
  assign pready          = 1'b1;
  assign pslverr         = psel && penable && !(selNode || selPhy);
  assign identifierValid = st_ff.identifierValid;
  assign nodeId          = {st_ff.busNumberField, st_ff.physicalNodeNumber};

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_nodeRd;
    apbSetup && selNode && !pwrite ##1 penable;
  endsequence

  property p_node_read;
    s_nodeRd |-> prdata[15:0] == $past(nodeId);
  endproperty
  a_node_read: assert property (p_node_read) else $error("node id read mismatch");

  property p_valid_clr;
    busRstEv && !regXfer |=> !identifierValid;
  endproperty
  a_valid_clr: assert property (p_valid_clr) else $error("valid not cleared on bus reset");

  property p_id_load;
    regXfer && rxAddr == nip_pkg::PHY_REG_ID |=> identifierValid
      && st_ff.root == $past(rxData[nip_pkg::ID_ROOT])
      && st_ff.cablePowerOk == $past(rxData[nip_pkg::ID_CPS]);
  endproperty
  a_id_load: assert property (p_id_load) else $error("node identity not loaded");

  property p_cps_hold;
    !regXfer |=> $stable(st_ff.cablePowerOk);
  endproperty
  a_cps_hold: assert property (p_cps_hold) else $error("cable power changed without report");

  property p_bus_reset;
    $rose(rst_n) |-> st_ff.busNumberField == nip_pkg::BUS_RESET;
  endproperty
  a_bus_reset: assert property (p_bus_reset) else $error("bus number reset value wrong");

  property p_node_ro;
    !regXfer |=> $stable(st_ff.physicalNodeNumber);
  endproperty
  a_node_ro: assert property (p_node_ro) else $error("node number changed by software");

  property p_resv;
    psel && penable && !pwrite && selNode |->
      prdata[29:28] == 2'h0 && prdata[26:16] == 11'h000;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved bits not zero");

  property p_resv_phy;
    psel && penable && !pwrite && selPhy |->
      prdata[30:28] == 3'h0 && prdata[13:12] == 2'h0;
  endproperty
  a_resv_phy: assert property (p_resv_phy) else $error("access reserved bits not zero");

  property p_done_clr;
    swReq && !regXfer |=> !st_ff.phyAccessDone;
  endproperty
  a_done_clr: assert property (p_done_clr) else $error("done not cleared by request");

  property p_done_set;
    regXfer |=> st_ff.phyAccessDone && st_ff.returnedPhyAddress == $past(rxAddr)
      && st_ff.returnedPhyData == $past(rxData);
  endproperty
  a_done_set: assert property (p_done_set) else $error("returned transfer not captured");

  property p_rd_sent;
    start && !preq.isWrite && !swReq |=> ##9 !st_ff.phyReadRequest;
  endproperty
  a_rd_sent: assert property (p_rd_sent) else $error("read request not cleared");

  property p_wr_sent;
    start && preq.isWrite && !swReq |=> st_ff.phyWriteRequest [*7] ##11 !st_ff.phyWriteRequest;
  endproperty
  a_wr_sent: assert property (p_wr_sent) else $error("write request not cleared");

  // Access register read returns the fields captured in the setup cycle
  sequence s_phyRd;
    apbSetup && selPhy && !pwrite ##1 penable;
  endsequence

  property p_phy_read;
    s_phyRd |-> prdata[nip_pkg::PA_DONE] == $past(st_ff.phyAccessDone)
      && prdata[nip_pkg::PA_RA_LO +: 4] == $past(st_ff.returnedPhyAddress)
      && prdata[nip_pkg::PA_RD_LO +: 8] == $past(st_ff.returnedPhyData);
  endproperty
  a_phy_read: assert property (p_phy_read) else $error("access register read mismatch");

  property p_bus_wr;
    apbWr && selNode |=> st_ff.busNumberField == $past(pwdata[nip_pkg::NID_BUS_LO +: nip_pkg::BUS_W]);
  endproperty
  a_bus_wr: assert property (p_bus_wr) else $error("bus number write lost");

  property p_target_wr;
    apbWr && selPhy |=> st_ff.targetPhyAddress == $past(pwdata[nip_pkg::PA_TA_LO +: 4])
      && st_ff.phyWriteValue == $past(pwdata[nip_pkg::PA_WV_LO +: 8]);
  endproperty
  a_target_wr: assert property (p_target_wr) else $error("target address or value write lost");

  property p_rd_req_set;
    apbWr && selPhy && pwdata[nip_pkg::PA_RDREQ] |=> st_ff.phyReadRequest;
  endproperty
  a_rd_req_set: assert property (p_rd_req_set) else $error("read request not taken");

  property p_wr_req_set;
    apbWr && selPhy && pwdata[nip_pkg::PA_WRREQ] |=> st_ff.phyWriteRequest;
  endproperty
  a_wr_req_set: assert property (p_wr_req_set) else $error("write request not taken");

  // A stray high on the request line would look like a new frame to the PHY
  property p_lreq_idle;
    !st_ff.sent |-> !phyLreq;
  endproperty
  a_lreq_idle: assert property (p_lreq_idle) else $error("request line active outside a frame");

  property p_valid_src;
    !(regXfer && rxAddr == nip_pkg::PHY_REG_ID) |=> !$rose(identifierValid);
  endproperty
  a_valid_src: assert property (p_valid_src) else $error("valid set without node number");

  property p_root_hold;
    !(regXfer && rxAddr == nip_pkg::PHY_REG_ID) |=> $stable(st_ff.root);
  endproperty
  a_root_hold: assert property (p_root_hold) else $error("root flag changed without report");

  property p_data_hold;
    !regXfer |=> $stable(st_ff.returnedPhyData)
      && $stable(st_ff.returnedPhyAddress);
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("returned fields changed without transfer");

  property p_done_hold;
    !regXfer |=> !$rose(st_ff.phyAccessDone);
  endproperty
  a_done_hold: assert property (p_done_hold) else $error("done set without transfer");
endmodule : nip_top
`default_nettype wire

// file: bench/nip_phy_model.sv
// PHY stand-in: decodes link request frames, keeps sixteen 8-bit registers
// and answers each read with a status transfer. Assumes it shares clk.
`timescale 1ns/1ps
`default_nettype none
module nip_phy_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Link-PHY pins
  input  wire logic       lreq,
  output logic      [1:0] phyCtl,
  output logic      [1:0] phyData
);
  logic [7:0]  regFile [16];
  logic [2:0]  lastType;
  int unsigned replyDelay;

  initial begin
    phyCtl     = 2'h0;
    phyData    = 2'h0;
    lastType   = 3'h0;
    replyDelay = 1;
    foreach (regFile[i]) regFile[i] = 8'h00;
  end

  // Lane 1 carries the earlier bit; idle lanes show the inverse, never stale data
  // Each symbol stands two cycles, else the link's pin filter would swallow it
  task automatic send_word(input logic [15:0] w);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      phyCtl  <= 2'h1;
      phyData <= w[15-2*i -: 2];
      @(posedge clk);
    end
    @(posedge clk);
    phyCtl  <= 2'h0;
    phyData <= ~w[1:0];
  endtask : send_word

  initial begin : decode
    logic [2:0] typ;
    logic [3:0] adr;
    logic [7:0] dat;
    forever begin
      @(posedge clk);
      if (rst_n === 1'b1 && lreq === 1'b1) begin
        for (int i = 2; i >= 0; i--) begin
          @(posedge clk);
          typ[i] = lreq;
        end
        for (int i = 3; i >= 0; i--) begin
          @(posedge clk);
          adr[i] = lreq;
        end
        if (typ == nip_pkg::LRQ_WR) begin
          for (int i = 7; i >= 0; i--) begin
            @(posedge clk);
            dat[i] = lreq;
          end
          regFile[adr] = dat;
        end
        @(posedge clk);
        lastType = typ;
        if (typ == nip_pkg::LRQ_RD) begin
          repeat (replyDelay) @(posedge clk);
          send_word({4'h0, adr, regFile[adr]});
        end
      end
    end
  end
endmodule : nip_phy_model
`default_nettype wire

// file: bench/nip_top_bench.sv
// Self-checking bench for the node identity and PHY access registers.
// Assumes the PHY model above on the link pins and an APB master here.
`timescale 1ns/1ps
`default_nettype none
module nip_top_bench;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic        phyLreq, identifierValid, errFlag;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdVal;
  logic [1:0]  phyCtl, phyData;
  logic [15:0] nodeId;
  int          n_mismatch = 0;
  int          n_checks = 0;
  localparam logic [11:0] NID = nip_pkg::OFS_NODE_ID;
  localparam logic [11:0] PAC = nip_pkg::OFS_PHY_ACC;

  nip_top i_nip_top (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .phyCtl(phyCtl), .phyData(phyData), .phyLreq(phyLreq), .identifierValid(identifierValid),
    .nodeId(nodeId));
  nip_phy_model i_nip_phy_model (.clk(clk), .rst_n(rst_n), .lreq(phyLreq), .phyCtl(phyCtl),
    .phyData(phyData));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : chk

  // Held until pready is seen high with psel and penable
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rdVal   = prdata;
    errFlag = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      n_mismatch++;
      stop_test();
    end
  endtask : apb

  task automatic poll(input logic [11:0] a, input logic [31:0] m, input logic [31:0] v);
    int n;
    n = 0;
    apb(1'b0, a, 32'h0);
    while ((rdVal & m) !== v && n < 200) begin
      apb(1'b0, a, 32'h0);
      n++;
    end
    if (n >= 200) begin
      n_mismatch++;
      stop_test();
    end
  endtask : poll

  task automatic t_reset();
    apb(1'b0, NID, 32'h0);
    chk(32'h0000_ffc0, rdVal);
    chk(32'h0, {31'h0, errFlag});
    chk(32'h0000_ffc0, {16'h0, nodeId});
    chk(32'h0, {31'h0, identifierValid});
    apb(1'b0, PAC, 32'h0);
    chk(32'h0, rdVal);
    apb(1'b0, 12'h0f0, 32'h0);
    chk(32'h1, {31'h0, errFlag});
    chk(32'h0, rdVal);
  endtask : t_reset

  task automatic t_self_id();
    i_nip_phy_model.send_word(16'h00ab);
    poll(PAC, 32'h8000_0000, 32'h8000_0000);
    chk(32'h80ab_0000, rdVal);
    apb(1'b0, NID, 32'h0);
    chk(32'hc800_ffea, rdVal);
    chk(32'h0000_ffea, {16'h0, nodeId});
    chk(32'h1, {31'h0, identifierValid});
  endtask : t_self_id

  task automatic t_bus_number();
    apb(1'b1, NID, 32'hffff_557f);
    apb(1'b0, NID, 32'h0);
    chk(32'hc800_556a, rdVal);
    chk(32'h0000_556a, {16'h0, nodeId});
  endtask : t_bus_number

  task automatic t_phy_write();
    apb(1'b1, PAC, 32'hf000_75a7);
    apb(1'b0, PAC, 32'h0);
    chk(32'h0000_4000, rdVal & 32'h8000_4000);
    poll(PAC, 32'h0000_4000, 32'h0);
    chk(32'h00ab_05a7, rdVal);
    chk(32'ha7, {24'h0, i_nip_phy_model.regFile[5]});
    chk(32'h5, {29'h0, i_nip_phy_model.lastType});
  endtask : t_phy_write

  task automatic t_phy_read();
    i_nip_phy_model.replyDelay = 5;
    apb(1'b1, PAC, 32'h0000_853c);
    poll(PAC, 32'h0000_8000, 32'h0);
    chk(32'h4, {29'h0, i_nip_phy_model.lastType});
    poll(PAC, 32'h8000_0000, 32'h8000_0000);
    chk(32'h85a7_053c, rdVal);
    chk(32'ha7, {24'h0, i_nip_phy_model.regFile[5]});
  endtask : t_phy_read

  task automatic t_bus_reset();
    i_nip_phy_model.send_word(16'h2100);
    poll(PAC, 32'h0f00_0000, 32'h0100_0000);
    apb(1'b0, NID, 32'h0);
    chk(32'h4800_556a, rdVal);
    chk(32'h0, {31'h0, identifierValid});
    i_nip_phy_model.send_word(16'h00fd);
    poll(PAC, 32'h0f00_0000, 32'h0);
    apb(1'b0, NID, 32'h0);
    chk(32'h8800_557f, rdVal);
    chk(32'h0000_557f, {16'h0, nodeId});
  endtask : t_bus_reset

  initial begin
    rst_n   = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_self_id();
    t_bus_number();
    t_phy_write();
    t_phy_read();
    t_bus_reset();
    stop_test();
  end
endmodule : nip_top_bench
`default_nettype wire
